// ### hdl/irq_priority_level_fields.sv
/*
  Bank of two-bit interrupt priority fields behind an AXI4-Lite slave,
  with per-source decode and a level arbiter toward the core.
  Assumes source requests are levels from logic on ref_clk.
*/
// How it works
// - debug sources decode 00 off, 01 level 1, 10 level 2, 11 level 3.
// - other sources decode 00 off, 01..11 as levels 0..2; never 3.
// - every field resets to 00, so every source starts disabled.
// - reserved bits read zero and ignore writes.
// - debug unit register: rx full 5-4, tx empty 3-2, trace 1-0.
// - flash register: buffers empty 15-14, command done 13-12, error 11-10.
// - same register: lock loss 9-8, low voltage 7-6, 5-4 reserved.
// - same register: external request B 3-2, external request A 1-0.
// - ports register: port D 15-14, port E 13-12, port F 11-10.
// - CAN message 9-8, wake 7-6, error 5-4, bus-off 3-2; 1-0 reserved.
// - serial reg: periph0 rx 15-14, periph1 tx 13-12, rx 11-10; 9-6 reserved.
// - serial reg: port A 5-4, port B 3-2, port C 1-0.
// - decoder reg: index, home, async rx, rx error, reserved, idle, tx, periph0 tx.
// - each register sits at base plus its own offset.
`timescale 1ns/10ps
module irq_priority_level_fields (
  // clock and reset
  input  wire logic                                ref_clk,
  input  wire logic                                resetn,
  // write address channel
  input  wire irq_prio_pkg::addr_t                 awaddr,
  input  wire logic                                awvalid,
  output logic                                     awready,
  // write data channel
  input  wire irq_prio_pkg::data_t                 wdata,
  input  wire logic [3:0]                          wstrb,
  input  wire logic                                wvalid,
  output logic                                     wready,
  // write response channel
  output logic [1:0]                               bresp,
  output logic                                     bvalid,
  input  wire logic                                bready,
  // read address channel
  input  wire irq_prio_pkg::addr_t                 araddr,
  input  wire logic                                arvalid,
  output logic                                     arready,
  // read data channel
  output irq_prio_pkg::data_t                      rdata,
  output logic [1:0]                               rresp,
  output logic                                     rvalid,
  input  wire logic                                rready,
  // peripheral requests
  input  wire logic [irq_prio_pkg::NUM_SRC-1:0]    srcReq,
  // toward the core
  output logic [irq_prio_pkg::NUM_SRC-1:0]         srcEnabled,
  output logic                                     coreIrqValid,
  output irq_prio_pkg::field_t                     coreIrqLevel,
  output irq_prio_pkg::src_idx_t                   coreIrqSource
);
  import irq_prio_pkg::*;

  // every check below runs on ref_clk and, except p_reset_clear, is off while reset is held
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  logic [REG_W-1:0]       prioQ [REG_FIRST:REG_LAST];
  logic                   awHeldQ;
  logic                   wHeldQ;
  addr_t                  awAddrQ;
  logic [REG_W-1:0]       wDataQ;
  logic [1:0]             wStrbQ;
  logic                   bvalidQ;
  logic [1:0]             brespQ;
  logic                   rvalidQ;
  data_t                  rdataQ;
  logic [1:0]             rrespQ;
  logic                   doWrite;
  logic                   wrMapped;
  logic [REG_W-1:0]       strbMask;
  logic [2*NUM_SRC-1:0]   fieldVec;
  logic [2*NUM_SRC-1:0]   levelVec;
  logic [NUM_SRC-1:0]     fieldOn;
  logic [NUM_SRC-1:0]     reqMasked;
  logic                   bestValid;
  field_t                 bestLevel;
  src_idx_t               bestSrc;
  logic [NUM_SRC-1:0]     srcEnabledQ;
  logic                   coreIrqValidQ;
  field_t                 coreIrqLevelQ;
  src_idx_t               coreIrqSourceQ;

  // word index of a byte address
  function automatic logic [5:0] regIndex(input addr_t addr);
    return addr[7:2];
  endfunction : regIndex

  // only aligned words at indices REG_FIRST..REG_LAST answer OKAY
  function automatic logic isMapped(input addr_t addr);
    logic [5:0] idx;
    idx = addr[7:2];
    return (addr[1:0] == 2'h0) && (idx >= 6'(REG_FIRST)) && (idx <= 6'(REG_LAST));
  endfunction : isMapped

  // write side: address and data are taken independently, in either order
  assign awready  = !awHeldQ && !bvalidQ;
  assign wready   = !wHeldQ && !bvalidQ;
  assign doWrite  = awHeldQ && wHeldQ;
  assign wrMapped = isMapped(awAddrQ);
  // only byte lanes 0 and 1 carry register bits; upper lanes are ignored
  assign strbMask = {{8{wStrbQ[1]}}, {8{wStrbQ[0]}}};

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      awHeldQ <= 1'b0;
      awAddrQ <= '0;
    end else if (awvalid && awready) begin
      awHeldQ <= 1'b1;
      awAddrQ <= awaddr;
    end else if (doWrite) begin
      awHeldQ <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wHeldQ <= 1'b0;
      wDataQ <= '0;
      wStrbQ <= 2'h0;
    end else if (wvalid && wready) begin
      wHeldQ <= 1'b1;
      wDataQ <= wdata[REG_W-1:0];
      wStrbQ <= wstrb[1:0];
    end else if (doWrite) begin
      wHeldQ <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bvalidQ <= 1'b0;
      brespQ  <= RESP_OKAY;
    end else if (doWrite) begin
      bvalidQ <= 1'b1;
      brespQ  <= wrMapped ? RESP_OKAY : RESP_DECERR;
    end else if (bready) begin
      bvalidQ <= 1'b0;
    end
  end

  assign bvalid = bvalidQ;
  assign bresp  = brespQ;

  // one process per register; reserved bits are never loaded
  for (genvar r = REG_FIRST; r <= REG_LAST; r++) begin : g_reg
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        prioQ[r] <= RESET_VALUE;
      end else if (doWrite && wrMapped && regIndex(awAddrQ) == 6'(r)) begin
        prioQ[r] <= (prioQ[r] & ~(REG_WRITE_MASK[r] & strbMask))
                  | (wDataQ & REG_WRITE_MASK[r] & strbMask);
      end
    end
  end

  // read side: one read at a time, answered the cycle after it is taken
  assign arready = !rvalidQ;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rvalidQ <= 1'b0;
      rdataQ  <= '0;
      rrespQ  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalidQ <= 1'b1;
      if (isMapped(araddr)) begin
        // upper half and reserved bits read zero
        rdataQ <= {16'h0000,
                   prioQ[regIndex(araddr)] & REG_WRITE_MASK[regIndex(araddr)]};
        rrespQ <= RESP_OKAY;
      end else begin
        rdataQ <= '0;
        rrespQ <= RESP_DECERR;
      end
    end else if (rready) begin
      rvalidQ <= 1'b0;
    end
  end

  assign rvalid = rvalidQ;
  assign rdata  = rdataQ;
  assign rresp  = rrespQ;

  // field placement and decode, one per source
  for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
    assign fieldVec[2*s +: 2] = prioQ[SRC_REG[s]][SRC_LSB[s] +: 2];

    irq_level_decode u_decode (
      .debugScale (s < NUM_DEBUG_SRC),
      .field      (fieldVec[2*s +: 2]),
      .enabled    (fieldOn[s]),
      .level      (levelVec[2*s +: 2])
    );
  end

  // a disabled field gates the request off before arbitration
  assign reqMasked = srcReq & fieldOn;

  irq_level_arbiter u_arbiter (
    .reqVec    (reqMasked),
    .levelVec  (levelVec),
    .bestValid (bestValid),
    .bestLevel (bestLevel),
    .bestSrc   (bestSrc)
  );

  // registered toward the core to keep the decode path off its inputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      srcEnabledQ    <= '0;
      coreIrqValidQ  <= 1'b0;
      coreIrqLevelQ  <= 2'h0;
      coreIrqSourceQ <= 5'h00;
    end else begin
      srcEnabledQ    <= fieldOn;
      coreIrqValidQ  <= bestValid;
      coreIrqLevelQ  <= bestLevel;
      coreIrqSourceQ <= bestSrc;
    end
  end

  assign srcEnabled    = srcEnabledQ;
  assign coreIrqValid  = coreIrqValidQ;
  assign coreIrqLevel  = coreIrqLevelQ;
  assign coreIrqSource = coreIrqSourceQ;

  // checks

  field_t selField;
  logic   reservedSet;

  assign selField = fieldVec[2*bestSrc +: 2];

  always_comb begin
    reservedSet = 1'b0;
    for (int r = REG_FIRST; r <= REG_LAST; r++) begin
      reservedSet = reservedSet | (|(prioQ[r] & ~REG_WRITE_MASK[r]));
    end
  end

  property p_debug_scale;
    bestValid && bestSrc < src_idx_t'(NUM_DEBUG_SRC)
      |-> bestLevel == selField ##1 coreIrqLevel == $past(selField);
  endproperty
  a_debug_scale: assert property (p_debug_scale)
    else $error("debug source level differs from its field");

  property p_std_scale;
    bestValid && bestSrc >= src_idx_t'(NUM_DEBUG_SRC)
      |-> bestLevel == field_t'(selField - 2'h1) && bestLevel != 2'h3;
  endproperty
  a_std_scale: assert property (p_std_scale)
    else $error("standard source level is not field minus one");

  property p_reset_clear;
    disable iff (1'b0)
    $rose(resetn) |-> !reservedSet && fieldOn == '0 && !coreIrqValid;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("fields not disabled after reset");

  property p_reserved_zero;
    !reservedSet && (!rvalid || rdata[DATA_W-1:REG_W] == 16'h0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit holds or reads a one");

  property p_debug_write;
    doWrite && awAddrQ == addr_t'(4*PRIORITY_DEBUG_UNIT_IDX) && wStrbQ == 2'h3
      |=> prioQ[PRIORITY_DEBUG_UNIT_IDX] == ($past(wDataQ) & 16'h003F)
          && fieldOn[0] == ($past(wDataQ[5:4]) != 2'h0);
  endproperty
  a_debug_write: assert property (p_debug_write)
    else $error("debug unit register write did not land in its fields");

  property p_flash_fields;
    doWrite && awAddrQ == addr_t'(4*PRIORITY_FLASH_CLOCK_EXT_IDX) && wStrbQ == 2'h3
      |=> fieldVec[7:6] == $past(wDataQ[15:14]) && fieldVec[19:18] == $past(wDataQ[1:0]);
  endproperty
  a_flash_fields: assert property (p_flash_fields)
    else $error("flash register fields misplaced");

  property p_lock_fields;
    doWrite && awAddrQ == addr_t'(4*PRIORITY_FLASH_CLOCK_EXT_IDX) && wStrbQ == 2'h3
      |=> fieldVec[13:12] == $past(wDataQ[9:8]) && fieldVec[15:14] == $past(wDataQ[7:6]);
  endproperty
  a_lock_fields: assert property (p_lock_fields)
    else $error("lock loss or low voltage field misplaced");

  property p_ports_fields;
    doWrite && awAddrQ == addr_t'(4*PRIORITY_PORTS_CAN_IDX) && wStrbQ == 2'h3
      |=> fieldVec[21:20] == $past(wDataQ[15:14]) && fieldVec[25:24] == $past(wDataQ[11:10]);
  endproperty
  a_ports_fields: assert property (p_ports_fields)
    else $error("port D or port F field misplaced");

  property p_serial_fields;
    doWrite && awAddrQ == addr_t'(4*PRIORITY_SERIAL_PORTS_IDX) && wStrbQ == 2'h3
      |=> fieldVec[35:34] == $past(wDataQ[15:14]) && fieldVec[39:38] == $past(wDataQ[11:10]);
  endproperty
  a_serial_fields: assert property (p_serial_fields)
    else $error("serial peripheral field misplaced");

  property p_decoder_fields;
    doWrite && awAddrQ == addr_t'(4*PRIORITY_DECODER_SERIAL_IDX) && wStrbQ == 2'h3
      |=> fieldVec[47:46] == $past(wDataQ[15:14]) && fieldVec[59:58] == $past(wDataQ[1:0]);
  endproperty
  a_decoder_fields: assert property (p_decoder_fields)
    else $error("decoder register field misplaced");

  property p_unmapped_read;
    arvalid && arready && !isMapped(araddr)
      |=> rvalid && rresp == RESP_DECERR && rdata == '0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not answered with decode error");

  property p_mapped_read;
    arvalid && arready && araddr == addr_t'(4*PRIORITY_PORTS_CAN_IDX)
      |=> rresp == RESP_OKAY && rdata[REG_W-1:0] == $past(prioQ[PRIORITY_PORTS_CAN_IDX]);
  endproperty
  a_mapped_read: assert property (p_mapped_read)
    else $error("register read returned the wrong word");

  property p_gate_disabled;
    bestValid |-> srcReq[bestSrc] && selField != FIELD_DISABLED;
  endproperty
  a_gate_disabled: assert property (p_gate_disabled)
    else $error("disabled source reached arbitration");

  property p_bvalid_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response dropped before bready");

  property p_rvalid_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read answer dropped before rready");

  c_write_done:   cover property (doWrite && wrMapped ##1 bvalid && bready);
  c_read_done:    cover property (arvalid && arready ##1 rvalid && rready);
  c_level_three:  cover property (coreIrqValid && coreIrqLevel == 2'h3);
  c_unmapped_wr:  cover property (doWrite && !wrMapped);
  c_unmapped_rd:  cover property (arvalid && arready && !isMapped(araddr));

endmodule : irq_priority_level_fields

// ### inc/irq_prio_pkg.sv
/*
  Shared constants for the interrupt priority level field bank: register
  indices, writable masks, field placement per source and bus codes.
  Assumes a 32-bit AXI4-Lite register bus and one system clock.
*/
package irq_prio_pkg;

  localparam int NUM_SRC       = 30;
  // sources 0..2 are the debug unit ones and use the 1..3 level scale
  localparam int NUM_DEBUG_SRC = 3;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;

  // register indices; byte address is four times the index
  localparam int PRIORITY_DEBUG_UNIT_IDX      = 1;
  localparam int PRIORITY_FLASH_CLOCK_EXT_IDX = 2;
  localparam int PRIORITY_PORTS_CAN_IDX       = 3;
  localparam int PRIORITY_SERIAL_PORTS_IDX    = 4;
  localparam int PRIORITY_DECODER_SERIAL_IDX  = 5;
  localparam int REG_FIRST = PRIORITY_DEBUG_UNIT_IDX;
  localparam int REG_LAST  = PRIORITY_DECODER_SERIAL_IDX;

  localparam logic [REG_W-1:0] RESET_VALUE = 16'h0000;

  // set bits are level fields, clear bits are reserved
  localparam logic [REG_W-1:0] REG_WRITE_MASK [REG_FIRST:REG_LAST] = '{
    16'h003F, 16'hFFCF, 16'hFFFC, 16'hFC3F, 16'hFF3F};

  // register index and low bit of each source's two-bit field
  localparam int SRC_REG [NUM_SRC] = '{
    1, 1, 1,
    2, 2, 2, 2, 2, 2, 2,
    3, 3, 3, 3, 3, 3, 3,
    4, 4, 4, 4, 4, 4,
    5, 5, 5, 5, 5, 5, 5};
  localparam int SRC_LSB [NUM_SRC] = '{
    4, 2, 0,
    14, 12, 10, 8, 6, 2, 0,
    14, 12, 10, 8, 6, 4, 2,
    14, 12, 10, 4, 2, 0,
    14, 12, 10, 8, 4, 2, 0};

  localparam logic [1:0] FIELD_DISABLED = 2'h0;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_DECERR    = 2'h3;

  typedef logic [1:0]        field_t;
  typedef logic [4:0]        src_idx_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] data_t;

endpackage : irq_prio_pkg

// ### hdl/irq_level_decode.sv
/*
  Decodes one two-bit priority field into an enable and a core level.
  Assumes the field comes straight from a register on the same clock.
*/
`timescale 1ns/10ps
module irq_level_decode (
  // field and scale select
  input  wire logic                 debugScale,
  input  wire irq_prio_pkg::field_t field,
  // decoded result
  output logic                      enabled,
  output irq_prio_pkg::field_t      level
);
  import irq_prio_pkg::*;

  assign enabled = (field != FIELD_DISABLED);
  // debug scale: 01..11 map to 1..3; others map to 0..2, so 3 is unreachable
  assign level = debugScale ? field : field_t'(field - 2'h1);

endmodule : irq_level_decode

// ### hdl/irq_level_arbiter.sv
/*
  Picks the highest level among the enabled requests; ties go to the
  lowest source index. Purely combinational; the caller registers it.
*/
`timescale 1ns/10ps
module irq_level_arbiter (
  // masked requests and their levels
  input  wire logic [irq_prio_pkg::NUM_SRC-1:0]   reqVec,
  input  wire logic [2*irq_prio_pkg::NUM_SRC-1:0] levelVec,
  // winner
  output logic                                    bestValid,
  output irq_prio_pkg::field_t                    bestLevel,
  output irq_prio_pkg::src_idx_t                  bestSrc
);
  import irq_prio_pkg::*;

  always_comb begin
    bestValid = 1'b0;
    bestLevel = 2'h0;
    bestSrc   = 5'h00;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (reqVec[i] && (!bestValid || levelVec[2*i +: 2] > bestLevel)) begin
        bestValid = 1'b1;
        bestLevel = levelVec[2*i +: 2];
        bestSrc   = src_idx_t'(i);
      end
    end
  end

endmodule : irq_level_arbiter

// ### dv/irq_src_model.sv
/*
  Model of the peripheral interrupt sources: drives request levels on
  ref_clk. Assumes the bench asks for changes through the drive task.
*/
`timescale 1ns/10ps
module irq_src_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // request levels toward the block
  output logic [29:0]      srcReq
);
  initial srcReq = 30'h0000_0000;

  // requests are plain levels, held until software code changes them
  task automatic drive(input logic [29:0] m);
    @(posedge ref_clk);
    srcReq <= resetn ? m : 30'h0000_0000;
  endtask : drive
endmodule : irq_src_model

// ### dv/irq_priority_level_fields_tb_top.sv
/*
  Self-checking bench for the priority field bank: AXI4-Lite register
  access, field placement, level decode and arbitration toward the core.
  Assumes the design answers in the cycles stated for its bus and core path.
*/
`timescale 1ns/10ps
module irq_priority_level_fields_tb_top;
  import irq_prio_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  addr_t awaddr = 8'h00, araddr = 8'h00;
  data_t wdata = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, coreIrqValid;
  logic [1:0] bresp, rresp, coreIrqLevel;
  logic [29:0] srcReq, srcEnabled;
  src_idx_t coreIrqSource;
  int mismatches = 0, total_checks = 0, cycles = 0;
  int srcReg[30] = '{1,1,1,2,2,2,2,2,2,2,3,3,3,3,3,3,3,4,4,4,4,4,4,5,5,5,5,5,5,5};
  int srcLsb[30] = '{4,2,0,14,12,10,8,6,2,0,14,12,10,8,6,4,2,14,12,10,4,2,0,14,12,10,8,4,2,0};
  logic [15:0] mask[1:5] = '{16'h003F, 16'hFFCF, 16'hFFFC, 16'hFC3F, 16'hFF3F};

  always #5 ref_clk = ~ref_clk;

  irq_priority_level_fields u_irq_priority_level_fields (.ref_clk(ref_clk), .resetn(resetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .srcReq(srcReq), .srcEnabled(srcEnabled),
    .coreIrqValid(coreIrqValid), .coreIrqLevel(coreIrqLevel), .coreIrqSource(coreIrqSource));
  irq_src_model u_irq_src_model (.ref_clk(ref_clk), .resetn(resetn), .srcReq(srcReq));

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // a hang is counted as one mismatch and closes the run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic doReset();
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
  endtask : doReset

  // handshakes are judged at the falling edge, where ready has settled
  task automatic axiWrite(input addr_t a, input logic [15:0] d, input logic [3:0] s,
                          output logic [1:0] resp);
    logic aw, w, b;
    @(posedge ref_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {16'h0000, d};
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge ref_clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      resp = bresp;
      @(posedge ref_clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
  endtask : axiWrite

  task automatic axiRead(input addr_t a, output data_t d, output logic [1:0] resp);
    logic ar, r;
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge ref_clk);
      ar = arvalid && arready;
      r = rvalid && rready;
      d = rdata;
      resp = rresp;
      @(posedge ref_clk);
      if (ar) arvalid <= 1'b0;
      if (r) rready <= 1'b0;
    end
  endtask : axiRead

  task automatic readCheck(input int idx, input logic [15:0] exp);
    data_t d;
    logic [1:0] r;
    axiRead(8'(4 * idx), d, r);
    check("read data", {16'h0000, exp}, d);
    check("read resp", RESP_OKAY, r);
  endtask : readCheck

  task automatic testResetValues();
    logic [1:0] r;
    axiWrite(8'h08, 16'hFFFF, 4'h3, r);
    doReset();
    for (int i = 1; i <= 5; i++) readCheck(i, 16'h0000);
    check("enables", 30'h0000_0000, srcEnabled);
  endtask : testResetValues

  task automatic testReserved();
    logic [1:0] r;
    for (int i = 1; i <= 5; i++) begin
      axiWrite(8'(4 * i), 16'hFFFF, 4'hF, r);
      check("write resp", RESP_OKAY, r);
      readCheck(i, mask[i]);
      axiWrite(8'(4 * i), 16'h0000, 4'hF, r);
    end
    axiWrite(8'h14, 16'hFFFF, 4'h1, r);
    readCheck(5, 16'h003F);
    axiWrite(8'h14, 16'h0000, 4'h3, r);
  endtask : testReserved

  task automatic testUnmapped();
    data_t d;
    logic [1:0] r;
    axiWrite(8'h00, 16'hFFFF, 4'h3, r);
    check("unmapped write resp", RESP_DECERR, r);
    axiWrite(8'h05, 16'hFFFF, 4'h3, r);
    check("misaligned write resp", RESP_DECERR, r);
    axiRead(8'h18, d, r);
    check("unmapped read resp", RESP_DECERR, r);
    check("unmapped read data", 32'h0000_0000, d);
    readCheck(1, 16'h0000);
  endtask : testUnmapped

  // every source and code: placement, enable, decoded level, masking
  task automatic testDecode();
    logic [1:0] r;
    for (int s = 0; s < 30; s++) begin
      u_irq_src_model.drive(30'(1) << s);
      for (int c = 3; c >= 0; c--) begin
        axiWrite(8'(4 * srcReg[s]), 16'(c) << srcLsb[s], 4'h3, r);
        repeat (3) @(negedge ref_clk);
        check("enables", c != 0 ? 30'(1) << s : 30'h0, srcEnabled);
        check("irq valid", c != 0, coreIrqValid);
        if (c != 0) begin
          check("irq level", s < 3 ? c : c - 1, coreIrqLevel);
          check("irq source", s, coreIrqSource);
        end
      end
    end
    u_irq_src_model.drive(30'h0000_0000);
  endtask : testDecode

  task automatic testArbitration();
    logic [1:0] r;
    u_irq_src_model.drive(30'h0000_0201);
    axiWrite(8'h08, 16'h0003, 4'h3, r);
    axiWrite(8'h04, 16'h0030, 4'h3, r);
    repeat (3) @(negedge ref_clk);
    check("winner", 0, coreIrqSource);
    check("winner level", 3, coreIrqLevel);
    axiWrite(8'h04, 16'h0010, 4'h3, r);
    repeat (3) @(negedge ref_clk);
    check("winner", 9, coreIrqSource);
    check("winner level", 2, coreIrqLevel);
    u_irq_src_model.drive(30'h0000_0000);
  endtask : testArbitration

  initial begin
    doReset();
    testResetValues();
    testReserved();
    testUnmapped();
    testDecode();
    testArbitration();
    test_done();
  end
endmodule : irq_priority_level_fields_tb_top
